// >>> hw/emb_defines.vh
// Functional notes
// R1: a read and a write buffer per master, 16 words in two halves
// R2: master 0 is core 0 plus DMA, master 1 core 1 plus DMA
// R3: burst or single follows from the address alone
// R4: single writes are posted, acknowledged at once
// R5: read hits and writes with room take no wait state
// R6: read data is zero without an access
// R7: shared-bus outputs are combinational
// R8: control bits 3-0 pick the X burst region
// R9: control bits 11-8 pick the Y burst region
// R10: control bits 19-16 pick the P burst region
// R11: X mode 00 never, 01 in region, 10 always
// R12: Y mode 00 never, 01 in region, 10 always, 11 reserved
// R13: P mode 00 never, 01 in region, 10 always, 11 reserved
// R14: a bypassing access leaves buffers alone
// R15: software keeps buffers coherent
// R16: read invalidate drops data, stalls, self-clears
// R17: write flush drains data, stalls, self-clears
// R18: burst reads are eight beats into one half
// R19: each half keeps a 26-bit base with space code
// R20: flush bursts carry one to eight words
// R21: after a posted write only single reads may ack until it went out
// R22: X mode 11 acts as no burst
// R23: maintenance stalls only its own master
`ifndef EMB_DEFINES_VH
`define EMB_DEFINES_VH

`define REG_BURST_CTRL   12'h000
`define REG_MAINT        12'h004
`define REG_STATUS       12'h008

`define X_BOUND_HI       3
`define X_BOUND_LO       0
`define Y_BOUND_HI       11
`define Y_BOUND_LO       8
`define P_BOUND_HI       19
`define P_BOUND_LO       16
`define X_MODE_HI        21
`define X_MODE_LO        20
`define Y_MODE_HI        23
`define Y_MODE_LO        22
`define P_MODE_HI        25
`define P_MODE_LO        24
`define BURST_CTRL_MASK  32'h03FF_0F0F
`define BURST_CTRL_RESET 32'h0000_0000

`define MAINT_INV_LO     0
`define MAINT_FLUSH_LO   2
`define MAINT_MASK       4'h3

`define MODE_NONE        2'h0
`define MODE_REGION      2'h1
`define MODE_ALL         2'h2

`define SPACE_X          2'h0
`define SPACE_Y          2'h1
`define SPACE_P          2'h2

`define HALF_SPAN        24'h00_0008
`define LAST_BEAT        3'h7
`define BURST_LEN        4'h8
`define FULL_COUNT       4'h8
`define ONE_WORD         4'h1

`define SRC_POST         3'h6
`define SRC_SREAD        3'h4
`define SRC_WBUF         3'h2
`define SRC_RBUF         3'h0

`endif

// >>> hw/burst_read_buffer.v
`timescale 1ns/100ps
`include "emb_defines.vh"
module burst_read_buffer #(
    parameter DW = 24,
    parameter AW = 26
) (
    input  wire          clk,
    input  wire          reset,
    input  wire          lookup,
    input  wire [AW-1:0] addr,
    output wire          hit,
    output wire [DW-1:0] rdata,
    output wire          fill_req,
    output reg  [AW-1:0] fill_addr,
    input  wire          fill_grant,
    input  wire          beat,
    input  wire [DW-1:0] beat_data,
    input  wire          invalidate,
    output wire          idle
);
    reg [DW-1:0] mem [0:15];
    reg [AW-1:0] base0;
    reg [AW-1:0] base1;
    reg [1:0]    valid;
    reg [1:0]    armed;
    reg          req_pend;
    reg          filling;
    reg          fill_half;
    reg [2:0]    cnt;

    function in_half;
        input [1:0]  sa;
        input [1:0]  sb;
        input [23:0] d;
        begin
            in_half = (sa == sb) && (d < `HALF_SPAN);
        end
    endfunction

    wire [23:0] d0 = addr[23:0] - base0[23:0];
    wire [23:0] d1 = addr[23:0] - base1[23:0];
    wire hit0 = valid[0] & in_half(addr[25:24], base0[25:24], d0);
    wire hit1 = valid[1] & in_half(addr[25:24], base1[25:24], d1);
    wire busy = req_pend | filling;
    wire [3:0] idx = hit1 ? {1'b1, d1[2:0]} : {1'b0, d0[2:0]};
    wire [AW-1:0] next_base = hit1 ? base1 + `HALF_SPAN : base0 + `HALF_SPAN;

    assign hit      = lookup & (hit0 | hit1);           // see R5
    assign rdata    = hit ? mem[idx] : {DW{1'b0}};
    assign fill_req = req_pend;
    assign idle     = ~busy;

    always @(posedge clk) begin
        if (filling & beat)
            mem[{fill_half, cnt}] <= beat_data;          // see R18
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            base0     <= {AW{1'b0}};
            base1     <= {AW{1'b0}};
            valid     <= 2'h0;
            armed     <= 2'h0;
            req_pend  <= 1'b0;
            filling   <= 1'b0;
            fill_half <= 1'b0;
            cnt       <= 3'h0;
            fill_addr <= {AW{1'b0}};
        end else begin
            if (invalidate) begin
                // an in-flight fill lands, then is dropped
                if (~busy) begin
                    valid <= 2'h0;                       // see R16
                    armed <= 2'h0;
                end
            end else if (lookup & ~busy) begin
                if (hit & armed[hit1]) begin
                    // first hit in a fresh half prefetches the next eight words
                    armed[hit1]   <= 1'b0;
                    valid[~hit1]  <= 1'b0;
                    fill_half     <= ~hit1;
                    fill_addr     <= next_base;
                    req_pend      <= 1'b1;
                    if (hit1)
                        base0 <= next_base;              // see R19
                    else
                        base1 <= next_base;
                end else if (~hit) begin
                    valid[~fill_half] <= 1'b0;
                    fill_half <= ~fill_half;
                    fill_addr <= addr;
                    req_pend  <= 1'b1;
                    if (fill_half)
                        base0 <= addr;                   // see R19
                    else
                        base1 <= addr;
                end
            end
            if (req_pend & fill_grant) begin
                req_pend <= 1'b0;
                filling  <= 1'b1;
                cnt      <= 3'h0;
            end
            if (filling & beat) begin
                cnt <= cnt + 3'h1;
                if (cnt == `LAST_BEAT) begin
                    filling          <= 1'b0;
                    valid[fill_half] <= 1'b1;            // see R18
                    armed[fill_half] <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> hw/burst_write_buffer.v
`timescale 1ns/100ps
`include "emb_defines.vh"
module burst_write_buffer #(
    parameter DW = 24,
    parameter AW = 26
) (
    input  wire          clk,
    input  wire          reset,
    input  wire          write,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output wire          ok,
    input  wire          flush,
    output wire          idle,
    output wire          flush_req,
    output wire [AW-1:0] flush_addr,
    output wire [3:0]    flush_len,
    input  wire          flush_grant,
    input  wire          beat,
    output wire [DW-1:0] beat_data
);
    reg [DW-1:0] mem [0:15];
    reg [AW-1:0] base [0:1];
    reg [3:0]    count [0:1];
    reg          cur;
    reg          pend;
    reg          flushing;
    reg          fh;
    reg [3:0]    bcnt;

    wire busy       = pend | flushing;
    wire cur_empty  = (count[cur] == 4'h0);
    wire full       = (count[cur] == `FULL_COUNT);
    wire [23:0] nxt = base[cur][23:0] + {20'h0_0000, count[cur]};
    wire seq        = (addr[25:24] == base[cur][25:24]) && (addr[23:0] == nxt);
    wire here       = cur_empty | (seq & ~full);
    wire swap       = ~here & (count[~cur] == 4'h0) & ~busy;

    assign ok         = write & (here | swap);          // see R5
    assign idle       = ~busy & (count[0] == 4'h0) & (count[1] == 4'h0);
    assign flush_req  = pend;
    assign flush_addr = base[fh];
    assign flush_len  = count[fh];                      // see R20
    assign beat_data  = mem[{fh, bcnt[2:0]}];

    always @(posedge clk) begin
        if (ok & here)
            mem[{cur, count[cur][2:0]}] <= wdata;
        else if (ok)
            mem[{~cur, 3'h0}] <= wdata;
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            base[0]  <= {AW{1'b0}};
            base[1]  <= {AW{1'b0}};
            count[0] <= 4'h0;
            count[1] <= 4'h0;
            cur      <= 1'b0;
            pend     <= 1'b0;
            flushing <= 1'b0;
            fh       <= 1'b0;
            bcnt     <= 4'h0;
        end else begin
            if (ok & here) begin
                count[cur] <= count[cur] + 4'h1;
                if (cur_empty)
                    base[cur] <= addr;                   // see R19
            end else if (ok) begin
                // not sequential or full: drain, go on in the other half
                pend       <= 1'b1;
                fh         <= cur;
                cur        <= ~cur;
                base[~cur] <= addr;
                count[~cur] <= `ONE_WORD;
            end else if (flush & ~busy & ~cur_empty) begin
                pend <= 1'b1;                            // see R17
                fh   <= cur;
                cur  <= ~cur;
            end
            if (pend & flush_grant) begin
                pend     <= 1'b0;
                flushing <= 1'b1;
                bcnt     <= 4'h0;
            end
            if (flushing & beat) begin
                bcnt <= bcnt + 4'h1;
                if (bcnt == count[fh] - 4'h1) begin
                    flushing  <= 1'b0;
                    count[fh] <= 4'h0;                   // see R20
                end
            end
        end
    end
endmodule

// >>> hw/external_memory_burst_buffer.v
`timescale 1ns/100ps
`include "emb_defines.vh"
module external_memory_burst_buffer #(
    parameter DW     = 24,
    parameter ADDR_W = 12
) (
    input  wire              clk,
    input  wire              reset,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    input  wire              m0_req,
    input  wire              m0_we,
    input  wire [1:0]        m0_space,
    input  wire [23:0]       m0_addr,
    input  wire [DW-1:0]     m0_wdata,
    output wire              m0_ack,
    output wire [DW-1:0]     m0_rdata,
    input  wire              m1_req,
    input  wire              m1_we,
    input  wire [1:0]        m1_space,
    input  wire [23:0]       m1_addr,
    input  wire [DW-1:0]     m1_wdata,
    output wire              m1_ack,
    output wire [DW-1:0]     m1_rdata,
    output wire              emc_req,
    output reg               emc_we,
    output reg  [1:0]        emc_space,
    output reg  [23:0]       emc_addr,
    output reg  [3:0]        emc_len,
    output reg  [DW-1:0]     emc_wdata,
    input  wire              emc_accept,
    input  wire              emc_beat,
    input  wire [DW-1:0]     emc_rdata
);
    reg  [31:0]   ext_burst_control_reg;
    reg  [3:0]    buffer_maintenance_reg;
    reg           post_pend;
    reg  [25:0]   post_addr;
    reg  [DW-1:0] post_data;
    reg           seq_busy;
    reg           seq_acc;
    reg  [2:0]    seq_src;
    reg  [3:0]    seq_cnt;
    reg  [2:0]    pick;
    reg  [3:0]    next_maint;

    wire [1:0]    req = {m1_req, m0_req};
    wire [1:0]    we  = {m1_we, m0_we};
    wire [25:0]   a0  = {m0_space, m0_addr};
    wire [25:0]   a1  = {m1_space, m1_addr};
    wire [1:0]    burst;
    wire [1:0]    stall;
    wire [1:0]    mstall;
    wire [1:0]    lookup;
    wire [1:0]    wr_go;
    wire [1:0]    post_take;
    wire [1:0]    sr_req;
    wire [1:0]    sr_done;
    wire [1:0]    rb_hit;
    wire [1:0]    rb_req;
    wire [1:0]    rb_idle;
    wire [1:0]    wb_ok;
    wire [1:0]    wb_req;
    wire [1:0]    wb_idle;
    wire [25:0]   rb_addr0;
    wire [25:0]   rb_addr1;
    wire [25:0]   wb_addr0;
    wire [25:0]   wb_addr1;
    wire [3:0]    wb_len0;
    wire [3:0]    wb_len1;
    wire [DW-1:0] rb_data0;
    wire [DW-1:0] rb_data1;
    wire [DW-1:0] wb_data0;
    wire [DW-1:0] wb_data1;
    wire [6:0]    src_req;
    wire [7:0]    grant;
    wire [7:0]    beat;

    function burst_ok;
        input [1:0]  space;
        input [3:0]  region;
        input [31:0] ctrl;
        reg   [1:0]  mode;
        reg   [3:0]  bound;
        begin
            mode  = `MODE_NONE;
            bound = 4'h0;
            case (space)
                `SPACE_X: begin
                    mode  = ctrl[`X_MODE_HI:`X_MODE_LO];
                    bound = ctrl[`X_BOUND_HI:`X_BOUND_LO];   // see R8
                end
                `SPACE_Y: begin
                    mode  = ctrl[`Y_MODE_HI:`Y_MODE_LO];
                    bound = ctrl[`Y_BOUND_HI:`Y_BOUND_LO];   // see R9
                end
                `SPACE_P: begin
                    mode  = ctrl[`P_MODE_HI:`P_MODE_LO];
                    bound = ctrl[`P_BOUND_HI:`P_BOUND_LO];   // see R10
                end
                default: mode = `MODE_NONE;
            endcase
            // see R11, see R12, see R13: reserved 11 falls to default (see R22)
            case (mode)
                `MODE_REGION: burst_ok = (region == bound);
                `MODE_ALL:    burst_ok = 1'b1;
                default:      burst_ok = 1'b0;
            endcase
        end
    endfunction

    // see R3
    assign burst[0] = burst_ok(m0_space, m0_addr[23:20], ext_burst_control_reg);
    assign burst[1] = burst_ok(m1_space, m1_addr[23:20], ext_burst_control_reg);

    // see R23: maintenance stalls only the owning master
    assign mstall = buffer_maintenance_reg[1:0] | buffer_maintenance_reg[3:2];
    assign stall  = mstall | {2{post_pend}};             // see R21
    assign lookup = req & ~we & burst & ~stall;
    assign wr_go  = req & we & burst & ~stall;
    // see R14: single accesses never reach the buffers
    assign sr_req = req & ~we & ~burst & ~mstall;
    assign post_take[0] = req[0] & we[0] & ~burst[0] & ~stall[0];   // see R4
    assign post_take[1] = req[1] & we[1] & ~burst[1] & ~stall[1] & ~post_take[0];

    // see R7: acknowledge and read data are pure decode, no register
    assign m0_ack   = rb_hit[0] | wb_ok[0] | post_take[0] | sr_done[0];
    assign m1_ack   = rb_hit[1] | wb_ok[1] | post_take[1] | sr_done[1];
    assign m0_rdata = rb_hit[0] ? rb_data0 :
                      sr_done[0] ? emc_rdata : {DW{1'b0}};          // see R6
    assign m1_rdata = rb_hit[1] ? rb_data1 :
                      sr_done[1] ? emc_rdata : {DW{1'b0}};

    // see R1, see R2: one read and one write buffer per master
    burst_read_buffer #(.DW(DW), .AW(26)) u_rb0 (
        .clk(clk), .reset(reset), .lookup(lookup[0]), .addr(a0),
        .hit(rb_hit[0]), .rdata(rb_data0), .fill_req(rb_req[0]),
        .fill_addr(rb_addr0), .fill_grant(grant[0]), .beat(beat[0]),
        .beat_data(emc_rdata), .invalidate(buffer_maintenance_reg[0]),
        .idle(rb_idle[0]));
    burst_read_buffer #(.DW(DW), .AW(26)) u_rb1 (
        .clk(clk), .reset(reset), .lookup(lookup[1]), .addr(a1),
        .hit(rb_hit[1]), .rdata(rb_data1), .fill_req(rb_req[1]),
        .fill_addr(rb_addr1), .fill_grant(grant[1]), .beat(beat[1]),
        .beat_data(emc_rdata), .invalidate(buffer_maintenance_reg[1]),
        .idle(rb_idle[1]));
    burst_write_buffer #(.DW(DW), .AW(26)) u_wb0 (
        .clk(clk), .reset(reset), .write(wr_go[0]), .addr(a0),
        .wdata(m0_wdata), .ok(wb_ok[0]), .flush(buffer_maintenance_reg[2]),
        .idle(wb_idle[0]), .flush_req(wb_req[0]), .flush_addr(wb_addr0),
        .flush_len(wb_len0), .flush_grant(grant[2]), .beat(beat[2]),
        .beat_data(wb_data0));
    burst_write_buffer #(.DW(DW), .AW(26)) u_wb1 (
        .clk(clk), .reset(reset), .write(wr_go[1]), .addr(a1),
        .wdata(m1_wdata), .ok(wb_ok[1]), .flush(buffer_maintenance_reg[3]),
        .idle(wb_idle[1]), .flush_req(wb_req[1]), .flush_addr(wb_addr1),
        .flush_len(wb_len1), .flush_grant(grant[3]), .beat(beat[3]),
        .beat_data(wb_data1));

    // external controller sequencer, one burst at a time
    assign src_req = {post_pend, sr_req, wb_req, rb_req};
    assign emc_req = seq_busy & ~seq_acc;
    assign grant   = {8{emc_accept & emc_req}} & (8'h01 << seq_src);
    assign beat    = {8{emc_beat & seq_busy & seq_acc}} & (8'h01 << seq_src);
    assign sr_done = beat[5:4];

    // posted writes go first so the stalled masters resume soonest
    always @* begin
        if (src_req[6])
            pick = `SRC_POST;
        else if (src_req[4])
            pick = `SRC_SREAD;
        else if (src_req[5])
            pick = `SRC_SREAD + 3'h1;
        else if (src_req[2])
            pick = `SRC_WBUF;
        else if (src_req[3])
            pick = `SRC_WBUF + 3'h1;
        else if (src_req[0])
            pick = `SRC_RBUF;
        else
            pick = `SRC_RBUF + 3'h1;
    end

    always @* begin
        emc_we    = 1'b0;
        emc_space = 2'h0;
        emc_addr  = 24'h00_0000;
        emc_len   = `ONE_WORD;
        emc_wdata = {DW{1'b0}};
        case (seq_src)
            3'h0: begin
                {emc_space, emc_addr} = rb_addr0;
                emc_len = `BURST_LEN;                    // see R18
            end
            3'h1: begin
                {emc_space, emc_addr} = rb_addr1;
                emc_len = `BURST_LEN;
            end
            3'h2: begin
                emc_we = 1'b1;
                {emc_space, emc_addr} = wb_addr0;
                emc_len   = wb_len0;                     // see R20
                emc_wdata = wb_data0;
            end
            3'h3: begin
                emc_we = 1'b1;
                {emc_space, emc_addr} = wb_addr1;
                emc_len   = wb_len1;
                emc_wdata = wb_data1;
            end
            3'h4: {emc_space, emc_addr} = a0;
            3'h5: {emc_space, emc_addr} = a1;
            3'h6: begin
                emc_we = 1'b1;
                {emc_space, emc_addr} = post_addr;
                emc_wdata = post_data;
            end
            default: emc_len = `ONE_WORD;
        endcase
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            seq_busy <= 1'b0;
            seq_acc  <= 1'b0;
            seq_src  <= 3'h0;
            seq_cnt  <= 4'h0;
        end else if (~seq_busy) begin
            if (|src_req) begin
                seq_busy <= 1'b1;
                seq_acc  <= 1'b0;
                seq_src  <= pick;
            end
        end else if (~seq_acc) begin
            if (emc_accept) begin
                seq_acc <= 1'b1;
                seq_cnt <= 4'h0;
            end
        end else if (emc_beat) begin
            seq_cnt <= seq_cnt + 4'h1;
            if (seq_cnt == emc_len - 4'h1)
                seq_busy <= 1'b0;
        end
    end

    // one posted slot suffices: all accesses but single reads stall meanwhile
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            post_pend <= 1'b0;
            post_addr <= 26'h000_0000;
            post_data <= {DW{1'b0}};
        end else if (|post_take) begin
            post_pend <= 1'b1;                           // see R4
            post_addr <= post_take[0] ? a0 : a1;
            post_data <= post_take[0] ? m0_wdata : m1_wdata;
        end else if (beat[6]) begin
            post_pend <= 1'b0;                           // see R21
        end
    end

    // register slave: one wait-free access phase
    wire setup  = psel & ~penable;
    wire access = psel & penable & pready;
    wire wr_mt  = access & pwrite & (paddr == `REG_MAINT);
    wire [3:0] set_bits = wr_mt ? pwdata[3:0] : 4'h0;
    wire [3:0] clr_bits = {wb_idle, rb_idle} & buffer_maintenance_reg;

    // a software set in the clearing cycle survives
    always @* begin
        next_maint = (buffer_maintenance_reg & ~clr_bits) | set_bits;   // see R16, see R17
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            ext_burst_control_reg  <= `BURST_CTRL_RESET;
            buffer_maintenance_reg <= 4'h0;
            pready                 <= 1'b0;
            pslverr                <= 1'b0;
            prdata                 <= 32'h0000_0000;
        end else begin
            buffer_maintenance_reg <= next_maint;
            pready <= setup;
            if (access & pwrite & (paddr == `REG_BURST_CTRL))
                ext_burst_control_reg <= pwdata & `BURST_CTRL_MASK;
            if (setup) begin
                pslverr <= 1'b0;
                case (paddr)
                    `REG_BURST_CTRL: prdata <= ext_burst_control_reg;
                    `REG_MAINT:      prdata <= {28'h000_0000, buffer_maintenance_reg};
                    `REG_STATUS:     prdata <= {26'h000_0000, wb_idle, rb_idle,
                                                seq_busy, post_pend};
                    default: begin
                        prdata  <= 32'h0000_0000;
                        pslverr <= 1'b1;
                    end
                endcase
            end else begin
                pslverr <= 1'b0;
                prdata  <= 32'h0000_0000;
            end
        end
    end
endmodule

// >>> tb/emb_sva.sv
`timescale 1ns/100ps
module emb_sva #(parameter DW = 24) (
    input wire          clk,
    input wire          reset,
    input wire          psel,
    input wire          penable,
    input wire          pready,
    input wire          pslverr,
    input wire          m0_req,
    input wire          m0_ack,
    input wire [DW-1:0] m0_rdata,
    input wire          emc_req,
    input wire          emc_accept,
    input wire          emc_we,
    input wire [23:0]   emc_addr,
    input wire [3:0]    emc_len
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_idle_data_zero: assert property (!m0_ack |-> m0_rdata == 0)
        else $error("read data not zero");
    a_ack_has_req: assert property (m0_ack |-> m0_req)
        else $error("ack without request");
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("stray error");
    a_emc_len_range: assert property (emc_req |-> emc_len != 0 && emc_len <= 8)
        else $error("bad length");
    a_read_len_eight: assert property (emc_accept && !emc_we |-> emc_len == 1 || emc_len == 8)
        else $error("bad read length");
    a_emc_req_held: assert property (emc_req && !emc_accept |=> emc_req && $stable(emc_addr))
        else $error("request dropped");
    cover property (m0_req && m0_ack);
    cover property (emc_accept && emc_we);
    cover property (pready && pslverr);
endmodule
bind external_memory_burst_buffer emb_sva #(.DW(DW)) sva_u (.clk, .reset, .psel, .penable,
    .pready, .pslverr, .m0_req, .m0_ack, .m0_rdata, .emc_req, .emc_accept, .emc_we, .emc_addr,
    .emc_len);

// >>> tb/emc_model.sv
`timescale 1ns/100ps
module emc_model (
    input wire        clk,
    input wire        reset,
    input wire        slow,
    input wire        emc_req,
    input wire [23:0] emc_addr,
    input wire [3:0]  emc_len,
    output reg        emc_accept,
    output reg        emc_beat,
    output reg [23:0] emc_rdata
);
    reg [1:0]  st;
    reg [3:0]  n;
    reg [23:0] a;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            {st, n, a, emc_accept, emc_beat, emc_rdata} <= 0;
        end else begin
            emc_accept <= 0;
            emc_beat <= 0;
            emc_rdata <= ~emc_rdata;
            n <= n + 1;
            if (st == 0 && !emc_req) n <= 0;
            else if (st == 0 && n >= {slow, slow}) begin
                emc_accept <= 1;
                st <= 1;
                a <= emc_addr;
                n <= 0;
            end else if (st == 1) begin
                emc_beat <= 1;
                emc_rdata <= a + n;
                if (n + 1 == emc_len) st <= 2;
            end else if (st == 2) begin
                st <= 0;
                n <= 0;
            end
        end
    end
endmodule

// >>> tb/external_memory_burst_buffer_tb.sv
`timescale 1ns/100ps
module external_memory_burst_buffer_tb;
    reg              clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, slow = 0, e;
    reg  [11:0]      paddr = 0;
    reg  [31:0]      pwdata = 0, v;
    reg  [1:0]       rq = 0, wr = 0;
    reg  [1:0][1:0]  sp = 0;
    reg  [1:0][23:0] ad = 0, wd = 0;
    reg  [23:0]      wa = 0;
    reg  [3:0]       ll = 0;
    wire [1:0][23:0] rd;
    wire [1:0]       ak;
    wire [31:0]      prdata;
    wire [23:0]      emc_addr, emc_rdata;
    wire [3:0]       emc_len;
    wire             pready, pslverr, emc_req, emc_accept, emc_beat;
    integer          bad_count = 0, checked = 0, nw;
    external_memory_burst_buffer dut_u (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .m0_req(rq[0]), .m0_we(wr[0]), .m0_space(sp[0]),
        .m0_addr(ad[0]), .m0_wdata(wd[0]), .m0_ack(ak[0]), .m0_rdata(rd[0]), .m1_req(rq[1]),
        .m1_we(wr[1]), .m1_space(sp[1]), .m1_addr(ad[1]), .m1_wdata(wd[1]), .m1_ack(ak[1]),
        .m1_rdata(rd[1]), .emc_req, .emc_we(), .emc_space(), .emc_addr, .emc_len, .emc_wdata(),
        .emc_accept, .emc_beat, .emc_rdata);
    emc_model far_u (.clk, .reset, .slow, .emc_req, .emc_addr, .emc_len, .emc_accept, .emc_beat,
        .emc_rdata);
    always @(posedge clk) if (emc_accept && emc_addr == wa) ll <= emc_len;
    initial forever #5 clk = ~clk;
    task report_and_stop; begin
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    end endtask
    task chk(input string nm, input [31:0] g, x); begin
        checked++;
        if (g !== x) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    end endtask
    task apb(input w, input [11:0] a, input [31:0] d); begin
        @(posedge clk); {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk); penable <= 1;
        do @(posedge clk); while (pready !== 1);
        {v, e} = {prdata, pslverr};
        {psel, penable} <= 0;
    end endtask
    task acc(input m, w, input [1:0] s, input [23:0] a, d); begin
        @(posedge clk); {rq[m], wr[m], sp[m], ad[m], wd[m]} <= {1'b1, w, s, a, d};
        nw = -1;
        do begin @(posedge clk); nw++; end while (ak[m] !== 1);
        v = rd[m];
        rq[m] <= 0;
    end endtask
    task maint(input [31:0] b); integer i; begin
        apb(1, 12'h004, b);
        v = b;
        for (i = 0; i < 50 && (v & b) != 0; i++) apb(0, 12'h004, 0);
        chk("maint bit", v & b, 0);
    end endtask
    task t_regs; begin
        apb(0, 0, 0);
        chk("ctrl reset", v, 0);
        apb(1, 0, 32'hFFFF_FFFF);
        apb(0, 0, 0);
        chk("ctrl fields", v, 32'h03FF_0F0F);
        apb(0, 12'h00C, 0);
        chk("unmapped", e, 1);
    end endtask
    task t_modes; integer s, md, k; begin
        for (s = 0; s < 3; s++) for (md = 0; md < 4; md++) for (k = 0; k < 2; k++) begin
            apb(1, 0, (md << (20 + 2 * s)) | 32'h0003_0303);
            wa = {k ? 4'h3 : 4'h5, 20'h1_0000 + 20'(s * 256 + md * 32)};
            ll = 0;
            acc(0, 0, s[1:0], wa, 0);
            chk("burst len", ll, (md == 2 || md == 1 && k) ? 8 : 1);
            chk("read data", v, wa);
        end
    end endtask
    task t_burst; begin
        apb(1, 0, 32'h0020_0000);
        acc(0, 0, 0, 24'h00_0400, 0);
        acc(0, 0, 1, 24'h00_0401, 0);
        acc(0, 0, 0, 24'h00_0405, 0);
        chk("hit data", v, 24'h00_0405);
        chk("hit wait", nw, 0);
        maint(1);
        wa = 24'h00_0405;
        ll = 0;
        acc(0, 0, 0, wa, 0);
        chk("refill len", ll, 8);
    end endtask
    task t_write; integer k; begin
        slow <= 1;
        for (k = 0; k < 3; k++) begin
            acc(0, 1, 0, 24'h00_0200 + k, k);
            chk("burst write wait", nw, 0);
        end
        wa = 24'h00_0200;
        ll = 0;
        maint(4);
        chk("flush len", ll, 3);
        acc(0, 1, 1, 24'h00_0300, 24'h12_3456);
        chk("posted wait", nw, 0);
        acc(1, 0, 1, 24'h00_0310, 0);
        chk("held off", nw >= 3, 1);
        chk("m1 data", v, 24'h00_0310);
    end endtask
    initial begin
        #400_000;
        bad_count++;
        report_and_stop;
    end
    initial begin
        repeat (8) @(posedge clk);
        reset <= 0;
        t_regs;
        t_modes;
        t_burst;
        t_write;
        report_and_stop;
    end
endmodule
